// ### pwct_pkg.sv
// pulse width count timer: constants, register map and carrier types
// assumes an APB slave with 32-bit data, one register per aligned word
//
// Functional notes
// - measurement counter is sixteen bits, counting up per reference tick
// - timer function raises an interrupt each programmed interval
// - timer function toggles a pulse output at each period end
// - reference clock chosen from three internal prescaled clocks
// - pulse measurement counts ticks between selected start and stop edges
// - five modes: high, low, rise period, fall period, any-to-opposite
// - optional eight-bit input divider by four to power n, n 1..4
// - measurement completion raises an interrupt request
// - single measurement stops counting; repeat mode restarts automatically
// - four count input pins; divide ratio set in its own register
// - sixteen-bit control register sets start, function, repeat, clock, mode, divider
// - four independent timer channels with own counter and registers
// - each channel raises completion and overflow interrupt sources
`default_nettype none
package pwct_pkg;
   localparam int NCH = 4;
   // ---------------------------------------------------------------
   // register map, channel stride 0x10
   // ---------------------------------------------------------------
   localparam logic [11:0] CH_STRIDE   = 12'h010;
   localparam logic [3:0]  OFS_CTRL    = 4'h0;
   localparam logic [3:0]  OFS_RESULT  = 4'h4;
   localparam logic [3:0]  OFS_DIV     = 4'h8;
   localparam logic [3:0]  OFS_RELOAD  = 4'hC;
   localparam logic [11:0] ADDR_IRQ_ST = 12'h040;
   localparam logic [11:0] ADDR_IRQ_MK = 12'h044;
   localparam logic [11:0] ADDR_COUNT0 = 12'h050;
   // ---------------------------------------------------------------
   // control register fields
   // ---------------------------------------------------------------
   localparam int CTL_START   = 0;
   localparam int CTL_FUNC    = 1;
   localparam int CTL_REPEAT  = 2;
   localparam int CTL_CKS_LO  = 3;
   localparam int CTL_MODE_LO = 5;
   localparam int CTL_DIVEN   = 8;
   localparam int CTL_BUSY    = 15;
   localparam logic [15:0] CTRL_RESET = 16'h0000;
   localparam logic [15:0] CTRL_WMASK = 16'h01FF;
   localparam logic [15:0] RELOAD_RESET = 16'hFFFF;
   localparam logic [1:0]  DIV_RESET = 2'h0;
   // prescaler taps: tick every 4, 16, 64 clocks
   localparam int PRE_W   = 6;
   localparam int TAP0    = 1;
   localparam int TAP1    = 3;
   localparam int TAP2    = 5;
   localparam int DIV_W   = 8;
   typedef enum logic [2:0] {
      PWCT_MODE_HIGH = 3'b000,
      PWCT_MODE_LOW  = 3'b001,
      PWCT_MODE_RISE = 3'b010,
      PWCT_MODE_FALL = 3'b011,
      PWCT_MODE_ANY  = 3'b100
   } pwct_mode_t;
   typedef enum logic [1:0] {
      PWCT_IDLE = 2'b00,
      PWCT_WAIT = 2'b01,
      PWCT_MEAS = 2'b10
   } pwct_state_t;
   // packed from control bit 8 down to bit 0
   typedef struct packed {
      logic       divEnable;
      logic [2:0] mode;
      logic [1:0] clockSel;
      logic       repeatOn;
      logic       timerFunc;
      logic       started;
   } pwct_cfg_t;
endpackage : pwct_pkg
`default_nettype wire

// ### pwct_pulse_src.sv
// pulse source driving the four count pins
// assumes run low holds the pins low; widths in ref_clk cycles
`timescale 1ns/1ns
`default_nettype none
module pwct_pulse_src (
   // clock and control
   input  wire logic        ref_clk,
   input  wire logic        run,
   input  wire logic [15:0] hiCyc,
   input  wire logic [15:0] loCyc,
   // count pins
   output logic      [3:0]  countIn = 4'h0
);
   int cnt [4] = '{0, 0, 0, 0};
   // channel c stays high c+1 times longer, so high-width and period results differ per channel
   always_ff @(posedge ref_clk) begin
      for (int c = 0; c < 4; c++) begin
         if (!run) begin
            countIn[c] <= 1'b0;
            cnt[c] <= 0;
         end else if (cnt[c] + 1 >=
                      (countIn[c] ? hiCyc * (c + 1) : loCyc)) begin
            countIn[c] <= ~countIn[c];
            cnt[c] <= 0;
         end else begin
            cnt[c] <= cnt[c] + 1;
         end
      end
   end
endmodule : pwct_pulse_src
`default_nettype wire

// ### pwct_timer.sv
// four-channel pulse width count timer with APB register access
// assumes count pins are asynchronous; one clock, ref_clk
`default_nettype none
`timescale 1ns/1ns
module pwct_timer #(
   parameter int NCH = pwct_pkg::NCH
) (
   // clock, reset, enable
   input  wire logic            ref_clk,
   input  wire logic            rstn,
   input  wire logic            clkEn,
   // apb slave
   input  wire logic            psel,
   input  wire logic            penable,
   input  wire logic            pwrite,
   input  wire logic [11:0]     paddr,
   input  wire logic [31:0]     pwdata,
   output logic                 pready,
   output logic [31:0]          prdata,
   output logic                 pslverr,
   // count pins and pulse outputs
   input  wire logic [NCH-1:0]  countIn,
   output logic      [NCH-1:0]  pulseOut,
   // interrupt
   output logic                 irq
);
   localparam int IW = 2 * NCH;
   logic              wrEn;
   logic              rdEn;
   logic [IW-1:0]     irqStatus;
   logic [IW-1:0]     irqMask;
   logic [IW-1:0]     irqEvent;
   localparam int PWCT_W = pwct_pkg::PRE_W;
   logic [PWCT_W-1:0] preCnt;
   logic [31:0]       next_prdata;
   logic              addrHit;

   // ---------------------------------------------------------------
   // apb decode
   // ---------------------------------------------------------------
   // zero wait state: an access is taken in its first access cycle,
   // and a frozen block holds the master in the access phase
   assign wrEn    = psel & penable & pwrite & clkEn;
   assign rdEn    = psel & penable & ~pwrite & clkEn;
   assign pready  = clkEn;
   assign pslverr = ~addrHit;

   // ---------------------------------------------------------------
   // shared prescaler
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         preCnt <= '0;
      end else if (clkEn) begin
         preCnt <= preCnt + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // channels
   // ---------------------------------------------------------------
   logic [15:0] ctrlRd   [NCH];
   logic [15:0] result   [NCH];
   logic [1:0]  divRatio [NCH];
   logic [15:0] reload   [NCH];
   logic [15:0] count    [NCH];

   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : gCh
         pwct_pkg::pwct_cfg_t   cfg;
         pwct_pkg::pwct_state_t state;
         logic [1:0]  syncIn;
         logic        pinLast;
         logic [7:0]  divCnt;
         logic        divOut;
         logic        divLast;
         logic        sig;
         logic        sigLast;
         logic        rise;
         logic        fall;
         logic        tick;
         logic        startEdge;
         logic        stopEdge;
         logic        wantFall;
         logic        complete;
         logic        overflow;
         logic        pulse;
         logic        ctrlWr;
         logic [11:0] base;
         logic [7:0]  divMax;

         assign base   = pwct_pkg::CH_STRIDE * 12'(g);
         assign ctrlWr = wrEn && paddr == base + {8'h00, pwct_pkg::OFS_CTRL};

         always_comb begin
            unique case (cfg.clockSel)
               2'b01:   tick = preCnt[pwct_pkg::TAP1:0] == '1;
               2'b10:   tick = preCnt[pwct_pkg::TAP2:0] == '1;
               default: tick = preCnt[pwct_pkg::TAP0:0] == '1;
            endcase
         end

         // only the second stage is read; the first may be metastable
         // pin synchroniser
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               syncIn  <= '0;
               pinLast <= 1'b0;
            end else if (clkEn) begin
               syncIn  <= {syncIn[0], countIn[g]};
               pinLast <= syncIn[1];
            end
         end

         // divider by 4**n, toggles out each half ratio
         always_comb begin
            unique case (divRatio[g])
               2'h0:    divMax = 8'h01;
               2'h1:    divMax = 8'h07;
               2'h2:    divMax = 8'h1F;
               default: divMax = 8'h7F;
            endcase
         end
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               divCnt <= '0;
               divOut <= 1'b0;
            end else if (clkEn) begin
               if (!cfg.started) begin
                  divCnt <= '0;
               end else if (syncIn[1] & ~pinLast) begin
                  if (divCnt == divMax) begin
                     divCnt <= '0;
                     divOut <= ~divOut;
                  end else begin
                     divCnt <= divCnt + 1'b1;
                  end
               end
            end
         end

         // switching the source can fake one edge; it falls in the idle
         // cycle after the control write, where the sequencer ignores it
         assign sig = cfg.divEnable ? divOut : syncIn[1];
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               sigLast <= 1'b0;
            end else if (clkEn) begin
               sigLast <= sig;
            end
         end
         assign rise = sig & ~sigLast;
         assign fall = ~sig & sigLast;

         always_comb begin
            startEdge = 1'b0;
            stopEdge  = 1'b0;
            unique case (cfg.mode)
               3'b001: begin
                  startEdge = fall;
                  stopEdge  = rise;
               end
               3'b010: begin
                  startEdge = rise;
                  stopEdge  = rise;
               end
               3'b011: begin
                  startEdge = fall;
                  stopEdge  = fall;
               end
               3'b100: begin
                  startEdge = rise | fall;
                  stopEdge  = wantFall ? fall : rise;
               end
               default: begin
                  startEdge = rise;
                  stopEdge  = fall;
               end
            endcase
         end

         assign overflow = cfg.started && state == pwct_pkg::PWCT_MEAS
                           && tick && count[g] == 16'hFFFF && !cfg.timerFunc;
         assign complete = cfg.started && state == pwct_pkg::PWCT_MEAS &&
                           (cfg.timerFunc ? (tick && count[g] == reload[g])
                                          : stopEdge);

         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               state    <= pwct_pkg::PWCT_IDLE;
               count[g] <= '0;
               wantFall <= 1'b0;
            end else if (clkEn) begin
               if (ctrlWr || !cfg.started) begin
                  state    <= pwct_pkg::PWCT_IDLE;
                  count[g] <= '0;
               end else begin
                  unique case (state)
                     pwct_pkg::PWCT_IDLE: begin
                        state <= cfg.timerFunc ? pwct_pkg::PWCT_MEAS
                                               : pwct_pkg::PWCT_WAIT;
                     end
                     pwct_pkg::PWCT_WAIT: begin
                        if (startEdge) begin
                           state    <= pwct_pkg::PWCT_MEAS;
                           wantFall <= rise;
                        end
                     end
                     pwct_pkg::PWCT_MEAS: begin
                        if (complete) begin
                           count[g] <= '0;
                           // repeat or stop
                           // period modes reuse the stop edge as the
                           // next start edge, so no period is lost
                           if (!cfg.timerFunc && cfg.mode ==
                               pwct_pkg::PWCT_MODE_RISE ||
                               !cfg.timerFunc && cfg.mode ==
                               pwct_pkg::PWCT_MODE_FALL)
                              state <= pwct_pkg::PWCT_MEAS;
                           else if (!cfg.timerFunc)
                              state <= pwct_pkg::PWCT_WAIT;
                           if (!cfg.repeatOn)
                              state <= pwct_pkg::PWCT_IDLE;
                        end else if (tick) begin
                           count[g] <= count[g] + 1'b1;
                        end
                     end
                     default: state <= pwct_pkg::PWCT_IDLE;
                  endcase
               end
            end
         end

         // control, divide ratio and reload registers
         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               cfg         <= pwct_pkg::pwct_cfg_t'(pwct_pkg::CTRL_RESET[8:0]);
               divRatio[g] <= pwct_pkg::DIV_RESET;
               reload[g]   <= pwct_pkg::RELOAD_RESET;
            end else if (clkEn) begin
               if (ctrlWr) begin
                  cfg <= pwct_pkg::pwct_cfg_t'(pwdata[8:0]);
               end else if (complete && !cfg.repeatOn) begin
                  cfg.started <= 1'b0;
               end
               if (wrEn && paddr == base + {8'h00, pwct_pkg::OFS_DIV})
                  divRatio[g] <= pwdata[1:0];
               if (wrEn && paddr == base + {8'h00, pwct_pkg::OFS_RELOAD})
                  reload[g] <= pwdata[15:0];
            end
         end

         always_ff @(posedge ref_clk or negedge rstn) begin
            if (!rstn) begin
               result[g] <= '0;
               pulse     <= 1'b0;
            end else if (clkEn) begin
               if (complete && !cfg.timerFunc)
                  result[g] <= count[g];
               if (!cfg.timerFunc || !cfg.started)
                  pulse <= 1'b0;
               else if (complete)
                  pulse <= ~pulse;
            end
         end
         assign pulseOut[g] = pulse;

         assign ctrlRd[g] = {(state != pwct_pkg::PWCT_IDLE), 6'h00, cfg};
         assign irqEvent[2*g]   = complete;
         assign irqEvent[2*g+1] = overflow;
      end
   endgenerate

   // ---------------------------------------------------------------
   // interrupts, cleared by status read; set wins
   // ---------------------------------------------------------------
   // completion sets a sticky bit
   always_ff @(posedge ref_clk or negedge rstn) begin
      if (!rstn) begin
         irqStatus <= '0;
         irqMask   <= '0;
      end else if (clkEn) begin
         if (rdEn && paddr == pwct_pkg::ADDR_IRQ_ST)
            irqStatus <= irqEvent;
         else
            irqStatus <= irqStatus | irqEvent;
         if (wrEn && paddr == pwct_pkg::ADDR_IRQ_MK)
            irqMask <= pwdata[IW-1:0];
      end
   end
   assign irq = |(irqStatus & irqMask);

   // ---------------------------------------------------------------
   // read mux
   // ---------------------------------------------------------------
   always_comb begin
      next_prdata = 32'h0000_0000;
      addrHit     = 1'b0;
      if (paddr == pwct_pkg::ADDR_IRQ_ST) begin
         next_prdata = {{(32-IW){1'b0}}, irqStatus};
         addrHit     = 1'b1;
      end else if (paddr == pwct_pkg::ADDR_IRQ_MK) begin
         next_prdata = {{(32-IW){1'b0}}, irqMask};
         addrHit     = 1'b1;
      end
      for (int i = 0; i < NCH; i++) begin
         if (paddr == pwct_pkg::CH_STRIDE * i[11:0]
                      + {8'h00, pwct_pkg::OFS_CTRL}) begin
            next_prdata = {16'h0000, ctrlRd[i]};
            addrHit     = 1'b1;
         end
         if (paddr == pwct_pkg::CH_STRIDE * i[11:0]
                      + {8'h00, pwct_pkg::OFS_RESULT}) begin
            next_prdata = {16'h0000, result[i]};
            addrHit     = 1'b1;
         end
         if (paddr == pwct_pkg::CH_STRIDE * i[11:0]
                      + {8'h00, pwct_pkg::OFS_DIV}) begin
            next_prdata = {30'h0, divRatio[i]};
            addrHit     = 1'b1;
         end
         if (paddr == pwct_pkg::CH_STRIDE * i[11:0]
                      + {8'h00, pwct_pkg::OFS_RELOAD}) begin
            next_prdata = {16'h0000, reload[i]};
            addrHit     = 1'b1;
         end
         if (paddr == pwct_pkg::ADDR_COUNT0 + 12'(4 * i)) begin
            next_prdata = {16'h0000, count[i]};
            addrHit     = 1'b1;
         end
      end
   end
   // data output from a flop would add a wait state; read data is muxed
   assign prdata = (psel & ~pwrite) ? next_prdata : 32'h0000_0000;
endmodule : pwct_timer
`default_nettype wire

// ### pwct_timer_asserts.sv
// checker for the pulse width count timer top ports
// assumes one clock domain; bound onto every pwct_timer below
`timescale 1ns/1ns
`default_nettype none
module pwct_timer_chk #(
   parameter int NCH = pwct_pkg::NCH
) (
   // clock, reset, enable
   input wire logic           ref_clk,
   input wire logic           rstn,
   input wire logic           clkEn,
   // apb
   input wire logic           psel,
   input wire logic           penable,
   input wire logic           pwrite,
   input wire logic [11:0]    paddr,
   input wire logic [31:0]    pwdata,
   input wire logic           pready,
   input wire logic [31:0]    prdata,
   input wire logic           pslverr,
   // outputs
   input wire logic [NCH-1:0] pulseOut,
   input wire logic           irq
);
   logic acc;
   assign acc = psel && penable;
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!rstn);
   // ----------
   // properties
   // ----------
   ready_follows_a: assert property (acc |-> pready == clkEn)
      else $error("pready differs from clkEn");
   unmapped_err_a: assert property (
      acc && paddr >= 12'h060 |-> pslverr && prdata == '0)
      else $error("unmapped access not refused");
   mapped_ok_a: assert property (
      acc && paddr < 12'h040 && paddr[1:0] == 2'h0 |-> !pslverr)
      else $error("channel register refused");
   idle_rdata_a: assert property (!psel || pwrite |-> prdata == '0)
      else $error("read data not zero outside reads");
   freeze_pulse_a: assert property (!clkEn |=> $stable(pulseOut))
      else $error("pulse output moved while frozen");
   freeze_irq_a: assert property (!clkEn |=> $stable(irq))
      else $error("irq moved while frozen");
   mask_off_a: assert property (
      acc && clkEn && pwrite && paddr == 12'h044
      && pwdata[2*NCH-1:0] == '0 |=> !irq)
      else $error("irq high with all sources masked");
   reset_quiet_a: assert property (
      $rose(rstn) |-> !irq && pulseOut == '0)
      else $error("outputs not idle after reset");
   cover property (acc && pslverr);
   cover property ($changed(pulseOut));
   cover property ($rose(irq));
endmodule : pwct_timer_chk
bind pwct_timer pwct_timer_chk #(.NCH(NCH)) chk_u (
   .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
   .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
   .pready(pready), .prdata(prdata), .pslverr(pslverr),
   .pulseOut(pulseOut), .irq(irq)
);
`default_nettype wire

// ### tb.sv
// self-checking bench for the pulse width count timer
// assumes pwct_pkg, the checker and the pulse source compiled first
`timescale 1ns/1ns
`default_nettype none
module tb;
   // -------
   // signals
   // -------
   localparam logic [15:0] HI = 16'h0010;
   localparam logic [15:0] LO = 16'h0018;
   logic        ref_clk = 1'b0;
   logic        rstn    = 1'b0;
   logic        clkEn   = 1'b1;
   logic        psel    = 1'b0;
   logic        penable = 1'b0;
   logic        pwrite  = 1'b0;
   logic [11:0] paddr   = 12'h000;
   logic [31:0] pwdata  = 32'h0;
   logic        pready, pslverr, irq, rerr;
   logic [31:0] prdata, rdat, acc, pwd;
   logic [3:0]  countIn, pulseOut;
   int          failures = 0;
   int          checks_done = 0;
   int          n, e, hw;
   int          expq[$];
   always #2 ref_clk = ~ref_clk;
   pwct_timer dut_u (
      .ref_clk(ref_clk), .rstn(rstn), .clkEn(clkEn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pready(pready), .prdata(prdata), .pslverr(pslverr),
      .countIn(countIn), .pulseOut(pulseOut), .irq(irq));
   pwct_pulse_src src_u (.ref_clk(ref_clk), .run(rstn), .hiCyc(HI),
      .loCyc(LO), .countIn(countIn));
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("CHECK FAILED t=%0t seen=%0h exp=%0h", $time, seen, exp);
      end
   endtask : chk
   task automatic results;
      if (failures == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : results
   // apb master: setup, access until pready, then one idle edge
   task automatic apb(input logic wr, input logic [11:0] a,
                      input logic [31:0] d);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge ref_clk);
      penable <= 1'b1;
      @(posedge ref_clk);
      while (pready !== 1'b1)
         @(posedge ref_clk);
      rdat = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge ref_clk);
   endtask : apb
   function automatic logic [11:0] ra(input int c, input logic [3:0] o);
      return 12'(c) * pwct_pkg::CH_STRIDE + 12'(o);
   endfunction : ra
   function automatic logic near(input logic [15:0] s, input int x);
      return ^s !== 1'bx && int'(s) >= x - 1 && int'(s) <= x + 1;
   endfunction : near
   task automatic waitTog(input int lim);
      logic p;
      p = pulseOut[0];
      n = 0;
      while (pulseOut[0] === p && n < lim) begin
         @(posedge ref_clk);
         n++;
      end
   endtask : waitTog
   task automatic pollSt(input logic [31:0] m, input int lim);
      acc = 32'h0;
      for (int i = 0; i < lim && (acc & m) !== m; i++) begin
         apb(1'b0, pwct_pkg::ADDR_IRQ_ST, 32'h0);
         acc = acc | rdat;
      end
      chk(acc & m, m);
   endtask : pollSt
   initial begin
      repeat (80000) @(posedge ref_clk);
      failures++;
      results();
   end
   initial begin
      void'($urandom(55878));
      repeat (2) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      for (int c = 0; c < 4; c++) begin
         apb(1'b0, ra(c, pwct_pkg::OFS_CTRL), 32'h0);
         chk(rdat, 32'(pwct_pkg::CTRL_RESET));
         apb(1'b0, ra(c, pwct_pkg::OFS_RELOAD), 32'h0);
         chk(rdat, 32'(pwct_pkg::RELOAD_RESET));
         apb(1'b0, ra(c, pwct_pkg::OFS_DIV), 32'h0);
         chk(rdat, 32'(pwct_pkg::DIV_RESET));
      end
      pwd = $urandom() & 32'h0000_01FE;
      apb(1'b1, ra(1, pwct_pkg::OFS_CTRL), pwd);
      apb(1'b0, ra(1, pwct_pkg::OFS_CTRL), 32'h0);
      chk(rdat, pwd & 32'(pwct_pkg::CTRL_WMASK));
      apb(1'b0, 12'h048, 32'h0);
      chk(32'(rerr), 32'h1);
      chk(rdat, 32'h0);
      apb(1'b1, pwct_pkg::ADDR_IRQ_MK, 32'h55);
      for (int m = 0; m < 5; m++) begin
         for (int c = 0; c < 4; c++) begin
            hw = HI * (c + 1);
            expq.push_back(m == 1 ? LO : (m == 2 || m == 3) ? hw + LO : hw);
            apb(1'b1, ra(c, pwct_pkg::OFS_CTRL), 32'h1 | 32'(m) << 5);
         end
         pollSt(32'h55, 400);
         for (int c = 0; c < 4; c++) begin
            apb(1'b0, ra(c, pwct_pkg::OFS_RESULT), 32'h0);
            e = expq.pop_front();
            chk(32'(near(rdat[15:0], e / 4) ||
                (m == 4 && near(rdat[15:0], LO / 4))), 32'h1);
         end
         chk(32'(irq), 32'h0);
      end
      apb(1'b1, pwct_pkg::ADDR_IRQ_MK, 32'h1);
      apb(1'b1, ra(0, pwct_pkg::OFS_RELOAD), 32'h3);
      for (int s = 0; s < 3; s++) begin
         apb(1'b1, ra(0, pwct_pkg::OFS_CTRL), 32'h7 | 32'(s) << 3);
         waitTog(2000);
         waitTog(2000);
         chk(n, 16 * 4 ** s);
      end
      clkEn <= 1'b0;
      repeat (8) @(posedge ref_clk);
      clkEn <= 1'b1;
      @(posedge ref_clk);
      chk(32'(irq), 32'h1);
      apb(1'b0, pwct_pkg::ADDR_IRQ_ST, 32'h0);
      chk(rdat & 32'h1, 32'h1);
      apb(1'b1, ra(0, pwct_pkg::OFS_CTRL), 32'h3);
      waitTog(2000);
      apb(1'b0, ra(0, pwct_pkg::OFS_CTRL), 32'h0);
      chk(rdat & 32'h1, 32'h0);
      apb(1'b0, pwct_pkg::ADDR_COUNT0, 32'h0);
      chk(rdat, 32'h0);
      waitTog(600);
      chk(n, 600);
      for (int d = 0; d < 4; d++) begin
         apb(1'b1, ra(0, pwct_pkg::OFS_DIV), 32'(d));
         apb(1'b1, ra(0, pwct_pkg::OFS_CTRL), 32'h141);
         apb(1'b0, pwct_pkg::ADDR_IRQ_ST, 32'h0);
         pollSt(32'h1, 9000);
         apb(1'b0, ra(0, pwct_pkg::OFS_RESULT), 32'h0);
         chk(32'(near(rdat[15:0], 10 * 4 ** (d + 1))), 32'h1);
      end
      // repeated high-width measurement keeps running after each result
      apb(1'b1, ra(0, pwct_pkg::OFS_CTRL), 32'h5);
      for (int k = 0; k < 2; k++) begin
         pollSt(32'h1, 400);
         apb(1'b0, ra(0, pwct_pkg::OFS_RESULT), 32'h0);
         chk(32'(near(rdat[15:0], HI / 4)), 32'h1);
      end
      apb(1'b0, ra(0, pwct_pkg::OFS_CTRL), 32'h0);
      chk(rdat & 32'h8001, 32'h8001);
      chk(32'(pulseOut), 32'h0);
      results();
   end
endmodule : tb
`default_nettype wire
